// [dv/sreq_host.sv]
// Link side model: serial host and bus controller
module sreq_host (
    input wire logic aclk,
    output logic rx_valid,
    output logic [7:0] rx_char,
    output logic bus_dev_clear
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rx_valid = 1'b0;
        rx_char = 8'hFF;
        bus_dev_clear = 1'b0;
    end
    // One strobed character, line inverted once released
    task automatic send(input logic [7:0] ch);
        @(posedge aclk);
        rx_valid <= 1'b1;
        rx_char <= ch;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_char <= ~ch;
    endtask : send
    task automatic bus_clear;
        @(posedge aclk);
        bus_dev_clear <= 1'b1;
        @(posedge aclk);
        bus_dev_clear <= 1'b0;
    endtask : bus_clear
endmodule : sreq_host

// [dv/sreq_top_tb.sv]
// Self-checking bench for the status and error queue block
`include "sreq_consts.svh"
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
 $display("mismatch %s exp %h got %h", n, e, g); end end
`define CHN(n,e,g) begin @(negedge aclk); `CHK(n,e,g) end
module sreq_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sreq_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
    sreq_event_type events = '0;
    logic err_push = 1'b0, ops_busy = 1'b0;
    logic [15:0] err_code = '0;
    logic rx_valid, bus_dev_clear;
    logic [7:0] rx_char;
    logic nv_psc = 1'b0;
    logic [7:0] nv_sre = 8'h20, nv_ese = 8'h01;
    logic srq, beep, err_ind, dtr, exec_hold, buf_flush, soft_reset;
    int num_errors = 0, check_count = 0, beeps = 0, flushes = 0, resets = 0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        beeps += int'(beep === 1'b1);
        flushes += int'(buf_flush === 1'b1);
        resets += int'(soft_reset === 1'b1);
    end
    sreq_top #(.ERR_DEPTH(20), .RX_DEPTH(4)) sreq_top_i (.*);
    sreq_host sreq_host_i (.*);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, aw, w, b;
        aw = 1'b1;
        w = 1'b1;
        b = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw | w) begin
            @(negedge aclk);
            ta = aw & s_axi_awready;
            tw = w & s_axi_wready;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            aw = aw & ~ta;
            w = w & ~tw;
        end
        while (!b) begin
            @(negedge aclk);
            b = s_axi_bvalid;
            @(posedge aclk);
        end
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, r;
        ta = 1'b0;
        r = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!ta) begin
            @(negedge aclk);
            ta = s_axi_arready;
            @(posedge aclk);
        end
        s_axi_arvalid <= 1'b0;
        while (!r) begin
            @(negedge aclk);
            r = s_axi_rvalid;
            rdat = s_axi_rdata;
            rrsp = s_axi_rresp;
            @(posedge aclk);
        end
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
        rd(a);
        `CHK(n, e, rdat)
    endtask : rc
    task automatic push(input logic [15:0] c);
        @(posedge aclk);
        err_push <= 1'b1;
        err_code <= c;
        @(posedge aclk);
        err_push <= 1'b0;
    endtask : push
    task automatic ques_pulse;
        @(posedge aclk) events.ques <= 16'h0004;
        @(posedge aclk) events.ques <= '0;
    endtask : ques_pulse
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(`SREQ_A_ESE, 32'h01, "ese");
        rc(`SREQ_A_SRE, 32'h20, "sre");
        rc(`SREQ_A_PSC, 32'h00, "psc");
        rd(8'h30);
        `CHK("resp", `SREQ_SLVERR, rrsp)
        $display("end init");
        ops_busy <= 1'b1;
        wr(`SREQ_A_CMD, 32'h02);
        rc(`SREQ_A_ESR, 32'h00, "esr busy");
        ops_busy <= 1'b0;
        repeat (3) @(posedge aclk);
        rc(`SREQ_A_STB, 32'h60, "stb");
        `CHN("srq", 1'b1, srq)
        rc(`SREQ_A_SPL, 32'h60, "poll");
        rc(`SREQ_A_STB, 32'h20, "stb poll");
        rc(`SREQ_A_ESR, 32'h01, "esr");
        rc(`SREQ_A_STB, 32'h00, "stb esr");
        wr(`SREQ_A_CMD, 32'h04);
        rc(`SREQ_A_OUT, 32'h01, "out");
        $display("end opc");
        wr(`SREQ_A_QEN, 32'h04);
        rc(`SREQ_A_QEN, 32'h04, "qen");
        ques_pulse();
        rc(`SREQ_A_STB, 32'h08, "stb q");
        rc(`SREQ_A_QEV, 32'h04, "qev");
        rc(`SREQ_A_QEV, 32'h00, "qev clr");
        $display("end ques");
        for (int i = 0; i < 21; i++) push(16'(16'hFF80 + i));
        `CHN("ind", 1'b1, err_ind)
        for (int i = 0; i < 19; i++) begin
            rc(`SREQ_A_ERR, 32'hFFFFFF80 + 32'(i), "err");
        end
        `CHK("beep", 21, beeps)
        rc(`SREQ_A_ERR, 32'hFFFFFEA2, "ovf");
        `CHN("ind", 1'b0, err_ind)
        rc(`SREQ_A_ERR, 32'h0, "none");
        push(16'hFF9C);
        wr(`SREQ_A_CMD, 32'h20);
        rc(`SREQ_A_ERR, 32'hFFFFFF9C, "err rst");
        `CHK("rst", 1, resets)
        push(16'hFF9C);
        ques_pulse();
        wr(`SREQ_A_CMD, 32'h01);
        rc(`SREQ_A_ERR, 32'h0, "err cls");
        rc(`SREQ_A_STB, 32'h0, "stb cls");
        $display("end queue");
        push(16'hFF9B);
        repeat (4) sreq_host_i.send(8'h41);
        @(posedge aclk);
        `CHN("dtr", 1'b0, dtr)
        sreq_host_i.send(`SREQ_CH_CTRLC);
        `CHN("dtr", 1'b1, dtr)
        rc(`SREQ_A_STS, 32'h101, "sts");
        `CHK("flush", 1, flushes)
        rc(`SREQ_A_ERR, 32'hFFFFFF9B, "err dcl");
        ops_busy <= 1'b1;
        wr(`SREQ_A_CMD, 32'h08);
        `CHN("hold", 1'b1, exec_hold)
        sreq_host_i.bus_clear();
        `CHN("hold", 1'b0, exec_hold)
        ops_busy <= 1'b0;
        wr(`SREQ_A_CMD, 32'h10);
        `CHN("flush", 3, flushes)
        $display("end clear");
        wr(`SREQ_A_SRE, 32'h48);
        rc(`SREQ_A_SRE, 32'h08, "sre wr");
        wr(`SREQ_A_ESE, 32'h3C);
        rc(`SREQ_A_ESE, 32'h3C, "ese wr");
        wr(`SREQ_A_PSC, 32'h01);
        rc(`SREQ_A_PSC, 32'h01, "psc wr");
        push(16'hFF99);
        nv_psc <= 1'b1;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rc(`SREQ_A_ESE, 32'h00, "ese pwr");
        rc(`SREQ_A_SRE, 32'h00, "sre pwr");
        rc(`SREQ_A_PSC, 32'h01, "psc pwr");
        rc(`SREQ_A_ERR, 32'h0, "err pwr");
        $display("end power");
        summarize();
    end
endmodule : sreq_top_tb

// [hdl/sreq_top.sv]
// Status byte, event registers, error queue and device clear
`include "sreq_consts.svh"
module sreq_top #(
    parameter int ERR_DEPTH = `SREQ_ERR_DEPTH,
    parameter int RX_DEPTH = `SREQ_RX_DEPTH
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire sreq_pkg::sreq_event_type events,
    input wire logic err_push,
    input wire logic [15:0] err_code,
    input wire logic ops_busy,
    input wire logic bus_dev_clear,
    input wire logic rx_valid,
    input wire logic [7:0] rx_char,
    input wire logic nv_psc,
    input wire logic [7:0] nv_sre,
    input wire logic [7:0] nv_ese,
    output logic srq,
    output logic beep,
    output logic err_ind,
    output logic dtr,
    output logic exec_hold,
    output logic buf_flush,
    output logic soft_reset
);
    import sreq_pkg::*;

    localparam int PW = $clog2(ERR_DEPTH);
    localparam int CW = $clog2(ERR_DEPTH + 1);
    localparam int RW = $clog2(RX_DEPTH + 1);

    function automatic sreq_reg_type decode(input logic [7:0] a);
        unique case (a)
            `SREQ_A_CMD: decode = R_CMD;
            `SREQ_A_ESE: decode = R_ESE;
            `SREQ_A_ESR: decode = R_ESR;
            `SREQ_A_QEV: decode = R_QEV;
            `SREQ_A_QEN: decode = R_QEN;
            `SREQ_A_SRE: decode = R_SRE;
            `SREQ_A_STB: decode = R_STB;
            `SREQ_A_SPL: decode = R_SPL;
            `SREQ_A_PSC: decode = R_PSC;
            `SREQ_A_ERR: decode = R_ERR;
            `SREQ_A_OUT: decode = R_OUT;
            `SREQ_A_STS: decode = R_STS;
            default: decode = R_NONE;
        endcase
    endfunction : decode

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        if (p == PW'(ERR_DEPTH - 1)) begin
            ptr_inc = '0;
        end else begin
            ptr_inc = p + PW'(1);
        end
    endfunction : ptr_inc

    logic aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff, rdata_ff;
    logic [3:0] wstrb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic [7:0] ese_ff, sre_ff, esr_ff, outbuf_ff;
    logic [15:0] qev_ff, qen_ff;
    logic psc_ff, init_ff, rqs_ff, req_prev_ff, mav_ff, beep_ff;
    logic opc_pend_ff, opcq_pend_ff, wai_pend_ff, dtr_ff, flush_ff;
    logic rst_ff;
    logic [15:0] mem [ERR_DEPTH];
    logic [PW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd, mem_addr;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [15:0] mem_data;
    logic mem_we;
    sreq_rx_type rx_state_ff;
    logic [RW-1:0] rx_cnt_ff;

    sreq_reg_type wsel, rsel;
    logic wr_en, rd_en, w_low, w_high;
    logic cls, opc_cmd, opcq_cmd, wai_cmd, dcl, ctrl_c;
    logic rd_esr, rd_qev, rd_spl, rd_err, rd_out;
    logic opc_done, opcq_done, pop, push_store, push_ovf, req_now;
    logic [7:0] stb_sum, stb_full;
    logic [31:0] rd_mux;
    sreq_status_type sts;

    // AXI4-Lite write channels, taken in either order
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready = !w_hold_ff && !bvalid_ff;
    assign wr_en = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign wsel = decode(awaddr_ff);
    assign w_low = wr_en && wstrb_ff[0];
    assign w_high = wr_en && wstrb_ff[1];
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
        end else if (wr_en) begin
            aw_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_hold_ff <= 1'b0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (wr_en) begin
            w_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= `SREQ_OKAY;
        end else if (wr_en) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= (wsel == R_NONE) ? `SREQ_SLVERR : `SREQ_OKAY;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // Read channel; side effects happen when the address is taken
    assign s_axi_arready = !rvalid_ff;
    assign rd_en = s_axi_arvalid && !rvalid_ff;
    assign rsel = decode(s_axi_araddr);
    assign rd_esr = rd_en && rsel == R_ESR;
    assign rd_qev = rd_en && rsel == R_QEV;
    assign rd_spl = rd_en && rsel == R_SPL;
    assign rd_err = rd_en && rsel == R_ERR;
    assign rd_out = rd_en && rsel == R_OUT;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Command strobes
    assign cls = w_low && wsel == R_CMD && wdata_ff[`SREQ_C_CLS];
    assign opc_cmd = w_low && wsel == R_CMD && wdata_ff[`SREQ_C_OPC];
    assign opcq_cmd = w_low && wsel == R_CMD && wdata_ff[`SREQ_C_OPCQ];
    assign wai_cmd = w_low && wsel == R_CMD && wdata_ff[`SREQ_C_WAI];
    assign ctrl_c = rx_valid && rx_char == `SREQ_CH_CTRLC;
    assign dcl = (w_low && wsel == R_CMD && wdata_ff[`SREQ_C_DCL])
        || bus_dev_clear || ctrl_c;
    assign opc_done = opc_pend_ff && !ops_busy;
    assign opcq_done = opcq_pend_ff && !ops_busy;

    // Status byte summary
    always_comb begin
        stb_sum = 8'h00;
        stb_sum[`SREQ_B_QUES] = |(qev_ff & qen_ff);
        stb_sum[`SREQ_B_MAV] = mav_ff;
        stb_sum[`SREQ_B_ESB] = |(esr_ff & ese_ff);
        stb_full = stb_sum;
        stb_full[`SREQ_B_RQS] = rqs_ff;
    end
    assign req_now = |(stb_sum & sre_ff);

    always_comb begin
        sts = '0;
        sts.err_count = 5'(cnt_ff);
        sts.opc_pend = opc_pend_ff;
        sts.opcq_pend = opcq_pend_ff;
        sts.wai_pend = wai_pend_ff;
        sts.dtr = dtr_ff;
        sts.rx_busy = rx_state_ff == RX_CMD;
        sts.rx_count = 8'(rx_cnt_ff);
    end

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (rsel)
            R_ESE: rd_mux[7:0] = ese_ff;
            R_ESR: rd_mux[7:0] = esr_ff;
            R_QEV: rd_mux[15:0] = qev_ff;
            R_QEN: rd_mux[15:0] = qen_ff;
            R_SRE: rd_mux[7:0] = sre_ff;
            R_STB, R_SPL: rd_mux[7:0] = stb_full;
            R_PSC: rd_mux[0] = psc_ff;
            R_ERR: begin
                if (cnt_ff != '0) begin
                    rd_mux = {{16{mem[rd_ff][15]}}, mem[rd_ff]};
                end else begin
                    rd_mux[15:0] = `SREQ_ERR_NONE;
                end
            end
            R_OUT: rd_mux[7:0] = mav_ff ? outbuf_ff : 8'h00;
            R_STS: rd_mux = sts;
            R_CMD, R_NONE: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `SREQ_OKAY;
        end else if (rd_en) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= (rsel == R_NONE) ? `SREQ_SLVERR : `SREQ_OKAY;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Power-up load of the standard event and service enable masks from stored settings
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            init_ff <= 1'b1;
        end else begin
            init_ff <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            psc_ff <= 1'b0;
        end else if (init_ff) begin
            psc_ff <= nv_psc;
        end else if (w_low && wsel == R_PSC) begin
            psc_ff <= wdata_ff[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ese_ff <= 8'h00;
            sre_ff <= 8'h00;
        end else if (init_ff) begin
            ese_ff <= nv_psc ? 8'h00 : nv_ese;
            sre_ff <= nv_psc ? 8'h00 : nv_sre;
        end else if (w_low) begin
            if (wsel == R_ESE) begin
                ese_ff <= wdata_ff[7:0];
            end
            if (wsel == R_SRE) begin
                sre_ff <= wdata_ff[7:0] & ~(8'h01 << `SREQ_B_RQS);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qen_ff <= 16'h0000;
        end else begin
            if (w_low && wsel == R_QEN) begin
                qen_ff[7:0] <= wdata_ff[7:0];
            end
            if (w_high && wsel == R_QEN) begin
                qen_ff[15:8] <= wdata_ff[15:8];
            end
        end
    end

    // Event registers; a new event wins over a clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            esr_ff <= 8'h00;
            qev_ff <= 16'h0000;
        end else begin
            esr_ff <= ((cls || rd_esr) ? 8'h00 : esr_ff) | events.std
                | (8'(opc_done) << `SREQ_B_OPC);
            qev_ff <= ((cls || rd_qev) ? 16'h0000 : qev_ff)
                | events.ques;
        end
    end

    // Request service and service request line
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_prev_ff <= 1'b0;
            rqs_ff <= 1'b0;
        end else begin
            req_prev_ff <= req_now;
            if (req_now && !req_prev_ff) begin
                rqs_ff <= 1'b1;
            end else if (cls || rd_spl || rd_esr || rd_qev) begin
                rqs_ff <= 1'b0;
            end
        end
    end
    assign srq = rqs_ff;

    // Pending operations and wait hold-off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            opc_pend_ff <= 1'b0;
            opcq_pend_ff <= 1'b0;
            wai_pend_ff <= 1'b0;
        end else begin
            opc_pend_ff <= opc_cmd || (opc_pend_ff && ops_busy);
            opcq_pend_ff <= opcq_cmd || (opcq_pend_ff && ops_busy);
            wai_pend_ff <= wai_cmd
                || (wai_pend_ff && ops_busy && !dcl);
        end
    end
    assign exec_hold = wai_pend_ff;

    // Output buffer: one reply word, flushed by device clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mav_ff <= 1'b0;
            outbuf_ff <= 8'h00;
        end else if (opcq_done) begin
            mav_ff <= 1'b1;
            outbuf_ff <= `SREQ_OPCQ_VAL;
        end else if (dcl || rd_out) begin
            mav_ff <= 1'b0;
        end
    end

    // Command reception and DTR handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= '0;
        end else if (dcl) begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= '0;
        end else if (rx_valid) begin
            if (rx_char == `SREQ_CH_LF) begin
                rx_state_ff <= RX_IDLE;
                rx_cnt_ff <= '0;
            end else begin
                rx_state_ff <= RX_CMD;
                if (rx_cnt_ff != RW'(RX_DEPTH)) begin
                    rx_cnt_ff <= rx_cnt_ff + RW'(1);
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dtr_ff <= 1'b1;
        end else if (dcl) begin
            dtr_ff <= 1'b1;
        end else if (rx_cnt_ff == RW'(RX_DEPTH)) begin
            dtr_ff <= 1'b0;
        end else if (rx_valid && rx_char == `SREQ_CH_LF) begin
            dtr_ff <= 1'b1;
        end
    end
    assign dtr = dtr_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flush_ff <= 1'b0;
            rst_ff <= 1'b0;
            beep_ff <= 1'b0;
        end else begin
            flush_ff <= dcl;
            rst_ff <= w_low && wsel == R_CMD && wdata_ff[`SREQ_C_RST];
            beep_ff <= err_push;
        end
    end
    assign buf_flush = flush_ff;
    assign soft_reset = rst_ff;
    assign beep = beep_ff;

    // Error queue occupancy and pointers
    assign pop = rd_err && cnt_ff != '0;
    assign push_store = err_push
        && (cls || pop || cnt_ff != CW'(ERR_DEPTH));
    assign push_ovf = err_push && !push_store;

    always_comb begin
        nxt_wr = wr_ff;
        nxt_rd = rd_ff;
        nxt_cnt = cnt_ff;
        if (cls) begin
            nxt_wr = '0;
            nxt_rd = '0;
            nxt_cnt = '0;
        end else if (pop) begin
            nxt_rd = ptr_inc(rd_ff);
            nxt_cnt = cnt_ff - CW'(1);
        end
        mem_we = push_store || push_ovf;
        mem_addr = nxt_wr;
        mem_data = err_code;
        if (push_store) begin
            nxt_wr = ptr_inc(nxt_wr);
            nxt_cnt = nxt_cnt + CW'(1);
        end else if (push_ovf) begin
            mem_addr = (wr_ff == '0) ? PW'(ERR_DEPTH - 1)
                : wr_ff - PW'(1);
            mem_data = `SREQ_ERR_OVF;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge aclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_data;
        end
    end
    assign err_ind = cnt_ff != '0;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_beep_per_err: assert property (err_push |=> beep)
        else $error("no beep after error");
    a_err_ind_off: assert property (
        pop && cnt_ff == CW'(1) && !err_push && !cls |=> !err_ind)
        else $error("error indicator stays on");
    a_queue_ovf: assert property (push_ovf && !pop && !cls
        |=> cnt_ff == CW'(ERR_DEPTH) && mem[(wr_ff == '0)
        ? PW'(ERR_DEPTH - 1) : wr_ff - PW'(1)] == `SREQ_ERR_OVF)
        else $error("overflow code missing");
    a_empty_read: assert property (rd_err && cnt_ff == '0
        && !err_push && !cls
        |=> s_axi_rdata == 32'h00000000 && $stable(rd_ff))
        else $error("empty queue read wrong");
    a_cls_clear: assert property (cls && events == '0
        && !err_push && !opc_done
        |=> esr_ff == 8'h00 && qev_ff == 16'h0000 && cnt_ff == '0)
        else $error("clear status incomplete");
    a_opc_done: assert property (opc_pend_ff && !ops_busy
        |=> esr_ff[`SREQ_B_OPC])
        else $error("operation complete not set");
    a_opcq_reply: assert property (opcq_pend_ff && !ops_busy
        |=> mav_ff && outbuf_ff == `SREQ_OPCQ_VAL)
        else $error("query reply missing");
    a_stb_keeps_rqs: assert property (rd_en && rsel == R_STB
        && rqs_ff && !cls |=> rqs_ff)
        else $error("status query cleared request");
    a_poll_clears: assert property (rd_spl && !cls
        && !(req_now && !req_prev_ff) && events.std == '0 && !opc_done
        |=> !srq && $stable(esr_ff))
        else $error("serial poll effect wrong");
    a_srq_rise: assert property ($rose(req_now) |=> srq)
        else $error("service request not raised");
    a_dev_clear: assert property (dcl && !opcq_done
        |=> !mav_ff && rx_state_ff == RX_IDLE && dtr)
        else $error("device clear incomplete");
    a_psc_init: assert property (init_ff && nv_psc
        |=> ese_ff == 8'h00 && sre_ff == 8'h00)
        else $error("power-on masks not cleared");

    c_overflow: cover property (push_ovf);
    c_srq_poll: cover property (srq ##1 rd_spl);
    c_ctrl_c: cover property (rx_state_ff == RX_CMD ##1 ctrl_c);
endmodule : sreq_top

// [include/sreq_consts.svh]
// Constants for the status reporting and error queue block
// Functional notes
// - Questionable enable write loads mask; enabled events feed STB bit 3.
// - Enable register reads return the mask bits as set.
// - Clear status clears all event registers and the status byte except MAV.
// - Standard event enable write loads mask; enabled bits feed STB.
// - Standard event register read returns its set bits.
// - Operation complete command sets event bit 0 once work is done.
// - Operation complete query puts 1 into the output buffer when done.
// - Power-on clear setting 1 clears both masks at power-up; readable.
// - Service enable write loads the mask except bit 6; its read returns it.
// - Status byte query equals serial poll but keeps request service.
// - Wait command holds further command execution until work finishes; device clear also ends the hold.
// - Device clear empties buffers, keeps status, queue and setup.
// - Device clear returns command reception to idle.
// - Ctrl-C on serial link acts as device clear, then raises DTR.
// - Error queue holds 20 entries, read oldest first.
// - Error indicator on while queue holds any entry.
// - One beeper pulse for every error generated.
// - Push into full queue overwrites newest slot with -350.
// - Reading empty queue returns 0 and changes nothing.
// - Queue emptied at power-up and by clear status, not by reset cmd.
// - Serial poll clears only the request service bit.
// - STB bit 5 set when any enabled standard event bit is set.
// - Reading questionable event register returns it, then clears it.
// - Request service bit drives the service request line.
`ifndef SREQ_CONSTS_SVH
`define SREQ_CONSTS_SVH
`define SREQ_A_CMD 8'h00
`define SREQ_A_ESE 8'h04
`define SREQ_A_ESR 8'h08
`define SREQ_A_QEV 8'h0C
`define SREQ_A_QEN 8'h10
`define SREQ_A_SRE 8'h14
`define SREQ_A_STB 8'h18
`define SREQ_A_SPL 8'h1C
`define SREQ_A_PSC 8'h20
`define SREQ_A_ERR 8'h24
`define SREQ_A_OUT 8'h28
`define SREQ_A_STS 8'h2C
`define SREQ_C_CLS 0
`define SREQ_C_OPC 1
`define SREQ_C_OPCQ 2
`define SREQ_C_WAI 3
`define SREQ_C_DCL 4
`define SREQ_C_RST 5
`define SREQ_B_OPC 0
`define SREQ_B_QUES 3
`define SREQ_B_MAV 4
`define SREQ_B_ESB 5
`define SREQ_B_RQS 6
`define SREQ_ERR_DEPTH 20
`define SREQ_ERR_OVF 16'hFEA2
`define SREQ_ERR_NONE 16'h0000
`define SREQ_OPCQ_VAL 8'h01
`define SREQ_CH_CTRLC 8'h03
`define SREQ_CH_LF 8'h0A
`define SREQ_RX_DEPTH 64
`define SREQ_OKAY 2'b00
`define SREQ_SLVERR 2'b10
`endif

// [include/sreq_pkg.sv]
// Types for the status reporting and error queue block
package sreq_pkg;
    typedef enum logic [3:0] {
        R_CMD, R_ESE, R_ESR, R_QEV, R_QEN, R_SRE, R_STB, R_SPL,
        R_PSC, R_ERR, R_OUT, R_STS, R_NONE
    } sreq_reg_type;
    typedef enum logic {RX_IDLE, RX_CMD} sreq_rx_type;
    typedef struct packed {
        logic [7:0] std;
        logic [15:0] ques;
    } sreq_event_type;
    typedef struct packed {
        logic [7:0] spare;
        logic [7:0] rx_count;
        logic [5:0] spare2;
        logic rx_busy;
        logic dtr;
        logic wai_pend;
        logic opcq_pend;
        logic opc_pend;
        logic [4:0] err_count;
    } sreq_status_type;
endpackage : sreq_pkg
